// ===== design/tcu_map.svh
// Register map, field codes and reset values of the timer capture unit
`ifndef TCU_MAP_SVH
`define TCU_MAP_SVH
// Register byte offsets
`define TCU_OFS_CTRL   8'h00
`define TCU_OFS_VLOW   8'h04
`define TCU_OFS_VHIGH  8'h08
`define TCU_OFS_STAT   8'h0C
`define TCU_OFS_MASK   8'h10
// Reset values
`define TCU_CTRL_RST   8'h00
`define TCU_VAL_RST    16'h0000
// Mode field position and codes
`define TCU_MODE_LSB   0
`define TCU_MODE_MSB   3
`define TCU_FLAG_BIT   0
`define TCU_MODE_OFF   4'h0
`define TCU_MODE_RSV1  4'h1
`define TCU_MODE_CMPT  4'h2
`define TCU_MODE_RSV3  4'h3
`define TCU_MODE_FALL  4'h4
`define TCU_MODE_RISE  4'h5
`define TCU_MODE_RISE4 4'h6
`define TCU_MODE_RISE16 4'h7
// Prescaler terminal counts
`define TCU_PS4_LAST   4'h3
`define TCU_PS16_LAST  4'hF
// Bus responses
`define TCU_RESP_OKAY  2'b00
`define TCU_RESP_SLVERR 2'b10
`endif

// ===== design/tcu_pkg.sv
// Types shared by the timer capture unit modules
`default_nettype none
package tcu_pkg;
`include "tcu_map.svh"
  typedef enum logic [3:0] {
    TCU_M_OFF    = `TCU_MODE_OFF,
    TCU_M_RSV1   = `TCU_MODE_RSV1,
    TCU_M_CMPT   = `TCU_MODE_CMPT,
    TCU_M_RSV3   = `TCU_MODE_RSV3,
    TCU_M_FALL   = `TCU_MODE_FALL,
    TCU_M_RISE   = `TCU_MODE_RISE,
    TCU_M_RISE4  = `TCU_MODE_RISE4,
    TCU_M_RISE16 = `TCU_MODE_RISE16
  } tcu_mode_t;
  // Register select from address decode
  typedef enum logic [2:0] {
    TCU_SEL_CTRL, TCU_SEL_VLOW, TCU_SEL_VHIGH, TCU_SEL_STAT, TCU_SEL_MASK, TCU_SEL_NONE
  } tcu_sel_t;
  // Pin drive group
  typedef struct packed {
    logic level;
    logic oe_n;
  } tcu_pin_t;
  typedef struct packed {
    logic meta;
    logic lvl;
  } tcu_sync_st_t;
  typedef struct packed {
    logic [3:0] cnt;
  } tcu_ps_st_t;
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [15:0] val;
    logic        flag;
    logic        irq_en;
    logic        prev;
    logic        match_prev;
    logic        cmp_out;
    logic        aw_held;
    logic [7:0]  awaddr;
    logic        w_held;
    logic [7:0]  wdata;
    logic        wstb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [7:0]  rdata;
    logic [1:0]  rresp;
  } tcu_st_t;
endpackage
`default_nettype wire

// ===== design/tcu_sync.sv
// Two-stage synchroniser for the capture pin
`default_nettype none
module tcu_sync (
  // Clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_rst_n,
  // Asynchronous level in, synchronised level out
  input  wire logic i_async,
  output logic      o_sync
);
  tcu_pkg::tcu_sync_st_t st_r;
  tcu_pkg::tcu_sync_st_t st_nxt;

  always_comb begin
    st_nxt      = st_r;
    st_nxt.meta = i_async;
    st_nxt.lvl  = st_r.meta; // Only reader of the first stage
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_sync = st_r.lvl;
endmodule // tcu_sync
`default_nettype wire

// ===== design/tcu_prescale.sv
// Capture event prescaler: turns pin edges into capture strobes
`default_nettype none
`include "tcu_map.svh"
module tcu_prescale (
  // Clock and reset
  input  wire logic               i_clk_sys,
  input  wire logic               i_rst_n,
  // Mode and edges
  input  wire tcu_pkg::tcu_mode_t i_mode,
  input  wire logic               i_rise,
  input  wire logic               i_fall,
  // Capture strobe
  output logic                    o_capture
);
  tcu_pkg::tcu_ps_st_t st_r;
  tcu_pkg::tcu_ps_st_t st_nxt;
  logic                is_cap;

  assign is_cap = (i_mode == tcu_pkg::TCU_M_FALL) || (i_mode == tcu_pkg::TCU_M_RISE) ||
                  (i_mode == tcu_pkg::TCU_M_RISE4) || (i_mode == tcu_pkg::TCU_M_RISE16);

  // Strobe per mode; reserved and compare codes never capture
  always_comb begin
    case (i_mode)
      tcu_pkg::TCU_M_FALL:   o_capture = i_fall;
      tcu_pkg::TCU_M_RISE:   o_capture = i_rise;
      tcu_pkg::TCU_M_RISE4:  o_capture = i_rise && ({2'b00, st_r.cnt[1:0]} == `TCU_PS4_LAST);
      tcu_pkg::TCU_M_RISE16: o_capture = i_rise && (st_r.cnt == `TCU_PS16_LAST);
      default:               o_capture = 1'b0;
    endcase
  end

  // Count rises; a new prescale keeps the old count, so a switch may fire early
  always_comb begin
    st_nxt = st_r;
    if (!is_cap) begin
      st_nxt.cnt = 4'h0;
    end else if (i_rise) begin
      st_nxt.cnt = st_r.cnt + 4'h1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  property p_ps_clear;
    !is_cap |=> (st_r.cnt == 4'h0);
  endproperty
  a_ps_clear: assert property (p_ps_clear) else $error("prescaler not cleared");

  property p_ps16;
    (i_mode == tcu_pkg::TCU_M_RISE16) && o_capture |-> (st_r.cnt == 4'hF) && i_rise;
  endproperty
  a_ps16: assert property (p_ps16) else $error("divide-16 strobe off count");

  property p_ps_keep;
    is_cap && !i_rise ##1 is_cap |-> $stable(st_r.cnt);
  endproperty
  a_ps_keep: assert property (p_ps_keep) else $error("prescaler count disturbed");
endmodule // tcu_prescale
`default_nettype wire

// ===== design/tcu_top.sv
// Timer capture unit: capture/compare core with AXI4-Lite registers
//
// Added by the designer: register access over AXI4-Lite and the register addresses.
`default_nettype none
`include "tcu_map.svh"
module tcu_top (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  // AXI4-Lite write address
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  // AXI4-Lite write response
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  // AXI4-Lite read data
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  // Timer count, same clock domain
  input  wire logic [15:0] i_timebase_one_count,
  // Port logic sharing the pin
  input  wire logic        i_pin_direction_bit,
  input  wire logic        i_port_latch,
  // Capture pin, three-signal form
  input  wire logic        i_capture_pin,
  output logic             o_capture_pin,
  output logic             o_capture_pin_oe_n,
  // Interrupt
  output logic             o_irq
);
  tcu_pkg::tcu_st_t   st_r;
  tcu_pkg::tcu_st_t   st_nxt;
  tcu_pkg::tcu_mode_t mode;
  tcu_pkg::tcu_sel_t  wsel;
  tcu_pkg::tcu_sel_t  rsel;
  logic               pin_lvl;
  logic               rise;
  logic               fall;
  logic               cap_stb;
  logic               match;
  logic               match_stb;
  logic               do_wr;
  logic               do_rd;
  logic               flag_set;
  logic               flag_clr;
  logic [7:0]         rd_val;

  // Shared decode of a register byte address
  function automatic tcu_pkg::tcu_sel_t tcu_decode(input logic [7:0] addr);
    tcu_pkg::tcu_sel_t sel;
    if (addr == `TCU_OFS_CTRL) begin
      sel = tcu_pkg::TCU_SEL_CTRL;
    end else if (addr == `TCU_OFS_VLOW) begin
      sel = tcu_pkg::TCU_SEL_VLOW;
    end else if (addr == `TCU_OFS_VHIGH) begin
      sel = tcu_pkg::TCU_SEL_VHIGH;
    end else if (addr == `TCU_OFS_STAT) begin
      sel = tcu_pkg::TCU_SEL_STAT;
    end else if (addr == `TCU_OFS_MASK) begin
      sel = tcu_pkg::TCU_SEL_MASK;
    end else begin
      sel = tcu_pkg::TCU_SEL_NONE;
    end
    return sel;
  endfunction

  assign mode = tcu_pkg::tcu_mode_t'(st_r.ctrl[`TCU_MODE_MSB:`TCU_MODE_LSB]);
  assign wsel = tcu_decode(st_r.awaddr);
  assign rsel = tcu_decode(i_araddr);

  tcu_sync u_sync (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_async   (i_capture_pin),
    .o_sync    (pin_lvl)
  );

  // Edges from the synchronised level; mode changes are not filtered
  // no glitch suppression
  assign rise = pin_lvl && !st_r.prev;
  assign fall = !pin_lvl && st_r.prev;

  // Strobe from the selected edge and prescale
  tcu_prescale u_prescale (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_mode    (mode),
    .i_rise    (rise),
    .i_fall    (fall),
    .o_capture (cap_stb)
  );

  // Compare hits once per arrival at the match, not every cycle it lasts
  assign match     = (i_timebase_one_count == st_r.val);
  assign match_stb = (mode == tcu_pkg::TCU_M_CMPT) && match && !st_r.match_prev;

  // Bus handshakes; one write and one read in flight
  assign o_awready = !st_r.aw_held;
  assign o_wready  = !st_r.w_held;
  assign o_arready = !st_r.rvalid;
  assign do_wr     = st_r.aw_held && st_r.w_held && !st_r.bvalid;
  assign do_rd     = i_arvalid && !st_r.rvalid;

  // Read mux; unused bits read as zero, except CTRL bits 7:4, which read back as written
  always_comb begin
    if (rsel == tcu_pkg::TCU_SEL_CTRL) begin
      rd_val = st_r.ctrl;
    end else if (rsel == tcu_pkg::TCU_SEL_VLOW) begin
      rd_val = st_r.val[7:0];
    end else if (rsel == tcu_pkg::TCU_SEL_VHIGH) begin
      rd_val = st_r.val[15:8];
    end else if (rsel == tcu_pkg::TCU_SEL_STAT) begin
      rd_val = {7'h00, st_r.flag};
    end else if (rsel == tcu_pkg::TCU_SEL_MASK) begin
      rd_val = {7'h00, st_r.irq_en};
    end else begin
      rd_val = 8'h00;
    end
  end

  // Flag events and software clears; set beats clear in the same cycle
  // capture sets flag
  assign flag_set = cap_stb || match_stb;
  assign flag_clr = (do_rd && (rsel == tcu_pkg::TCU_SEL_STAT)) ||
                    (do_wr && st_r.wstb && (wsel == tcu_pkg::TCU_SEL_STAT) &&
                     st_r.wdata[`TCU_FLAG_BIT]);

  // Next-state logic for registers, pin state and bus channels
  always_comb begin
    st_nxt            = st_r;
    st_nxt.prev       = pin_lvl;
    st_nxt.match_prev = match;
    // Write address and data, taken in either order
    if (i_awvalid && o_awready) begin
      st_nxt.aw_held = 1'b1;
      st_nxt.awaddr  = i_awaddr;
    end
    if (i_wvalid && o_wready) begin
      st_nxt.w_held = 1'b1;
      st_nxt.wdata  = i_wdata[7:0];
      st_nxt.wstb   = i_wstrb[0];
    end
    // Register writes; only byte lane 0 carries data
    if (do_wr) begin
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = (wsel == tcu_pkg::TCU_SEL_NONE) ? `TCU_RESP_SLVERR : `TCU_RESP_OKAY;
      if (st_r.wstb) begin
        if (wsel == tcu_pkg::TCU_SEL_CTRL) begin
          st_nxt.ctrl = st_r.wdata;
        end else if (wsel == tcu_pkg::TCU_SEL_VLOW) begin
          st_nxt.val[7:0] = st_r.wdata;
        end else if (wsel == tcu_pkg::TCU_SEL_VHIGH) begin
          st_nxt.val[15:8] = st_r.wdata;
        end else if (wsel == tcu_pkg::TCU_SEL_MASK) begin
          st_nxt.irq_en = st_r.wdata[`TCU_FLAG_BIT];
        end
      end
    end
    if (st_r.bvalid && i_bready) begin
      st_nxt.bvalid  = 1'b0;
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held  = 1'b0;
    end
    // Read data registered at address acceptance
    if (do_rd) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = rd_val;
      st_nxt.rresp  = (rsel == tcu_pkg::TCU_SEL_NONE) ? `TCU_RESP_SLVERR : `TCU_RESP_OKAY;
    end else if (st_r.rvalid && i_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (cap_stb) begin
      st_nxt.val = i_timebase_one_count; // Capture outranks a same-cycle write
    end
    if (match_stb) begin
      st_nxt.cmp_out = !st_r.cmp_out;
    end
    if (mode == tcu_pkg::TCU_M_OFF) begin
      st_nxt.cmp_out = 1'b0;
    end
    st_nxt.flag = flag_set || (st_r.flag && !flag_clr);
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r      <= '0;
      st_r.ctrl <= `TCU_CTRL_RST;
      st_r.val  <= `TCU_VAL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Pin drive: compare owns the pin, else the port latch when set as output
  // port write reaches edge logic
  always_comb begin
    if (mode == tcu_pkg::TCU_M_CMPT) begin
      o_capture_pin      = st_r.cmp_out;
      o_capture_pin_oe_n = 1'b0;
    end else if (!i_pin_direction_bit) begin
      o_capture_pin      = i_port_latch;
      o_capture_pin_oe_n = 1'b0;
    end else begin
      o_capture_pin      = 1'b0;
      o_capture_pin_oe_n = 1'b1;
    end
  end

  // Bus outputs straight from state
  assign o_bvalid = st_r.bvalid;
  assign o_bresp  = st_r.bresp;
  assign o_rvalid = st_r.rvalid;
  assign o_rresp  = st_r.rresp;
  assign o_rdata  = {24'h00_0000, st_r.rdata};
  assign o_irq    = st_r.flag && st_r.irq_en;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  property p_cap_copy;
    logic [15:0] t;
    (cap_stb, t = i_timebase_one_count) |=> (st_r.val == t);
  endproperty
  a_cap_copy: assert property (p_cap_copy) else $error("capture value wrong");

  property p_fall_cap;
    (mode == tcu_pkg::TCU_M_FALL) && fall |-> cap_stb;
  endproperty
  a_fall_cap: assert property (p_fall_cap) else $error("falling edge missed");

  property p_rise_cap;
    (mode == tcu_pkg::TCU_M_RISE) && rise |-> cap_stb ##1 st_r.flag;
  endproperty
  a_rise_cap: assert property (p_rise_cap) else $error("rising edge missed");

  property p_flag_set;
    cap_stb |=> st_r.flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");

  property p_flag_hold;
    st_r.flag && !flag_clr |=> st_r.flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost");

  property p_rsv_none;
    (mode == tcu_pkg::TCU_M_RSV1) || (mode == tcu_pkg::TCU_M_RSV3) |-> !cap_stb;
  endproperty
  a_rsv_none: assert property (p_rsv_none) else $error("reserved mode captured");

  property p_cmp_toggle;
    match_stb && (st_nxt.ctrl == st_r.ctrl)
      |=> (st_r.cmp_out != $past(st_r.cmp_out)) && st_r.flag;
  endproperty
  a_cmp_toggle: assert property (p_cmp_toggle) else $error("compare toggle missing");

  property p_off_release;
    (mode == tcu_pkg::TCU_M_OFF) && i_pin_direction_bit |-> o_capture_pin_oe_n;
  endproperty
  a_off_release: assert property (p_off_release) else $error("pin not released");

  property p_port_event;
    (mode == tcu_pkg::TCU_M_RISE) && !i_pin_direction_bit && rise |-> ##1 st_r.flag;
  endproperty
  a_port_event: assert property (p_port_event) else $error("port edge lost");

  property p_wr_resp;
    do_wr |=> o_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("no write response");

  property p_rd_resp;
    do_rd |=> o_rvalid;
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("no read response");

  property p_cap_only;
    cap_stb |-> ((mode == tcu_pkg::TCU_M_FALL) && fall) ||
      (rise && ((mode == tcu_pkg::TCU_M_RISE) || (mode == tcu_pkg::TCU_M_RISE4) ||
                (mode == tcu_pkg::TCU_M_RISE16)));
  endproperty
  a_cap_only: assert property (p_cap_only) else $error("capture without selected edge");

  property p_overwrite;
    cap_stb && st_r.flag |=> (st_r.val == $past(i_timebase_one_count));
  endproperty
  a_overwrite: assert property (p_overwrite) else $error("unread value not replaced");

  property p_flag_clr;
    flag_clr && !flag_set |=> !st_r.flag;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("software clear ignored");

  property p_irq_on;
    flag_set && st_nxt.irq_en |=> o_irq;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("interrupt not raised");

  property p_off_latch;
    (mode == tcu_pkg::TCU_M_OFF) |=> !st_r.cmp_out;
  endproperty
  a_off_latch: assert property (p_off_latch) else $error("compare latch not cleared");

  property p_cmp_drive;
    (mode == tcu_pkg::TCU_M_CMPT) |-> !o_capture_pin_oe_n && (o_capture_pin == st_r.cmp_out);
  endproperty
  a_cmp_drive: assert property (p_cmp_drive) else $error("compare pin not driven");
endmodule // tcu_top
`default_nettype wire

// ===== sim/tcu_pin_src.sv
// External event source model standing on the capture pin
`default_nettype none
module tcu_pin_src (
  // Design drive of the pin
  input  wire logic i_dut_lvl,
  input  wire logic i_dut_oe_n,
  // Level commanded by the bench
  input  wire logic i_ext_lvl,
  // Resolved pad level
  output logic      o_pad
);
  timeunit 1ns;
  timeprecision 1ps;
  // source drives only while the pin is an input
  // It yields whenever the design drives, so the pad never sees contention
  always_comb o_pad = i_dut_oe_n ? i_ext_lvl : i_dut_lvl;
endmodule // tcu_pin_src
`default_nettype wire

// ===== sim/tb_timer_capture_unit.sv
// Self-checking bench of the timer capture unit
`default_nettype none
`include "tcu_map.svh"
module tb_timer_capture_unit;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [3:0]  mode;
    logic [4:0]  n;
    logic [15:0] val;
    logic        flag;
  } tcu_row_t;
  localparam logic [7:0] a_ctl = `TCU_OFS_CTRL;
  localparam logic [7:0] a_lo  = `TCU_OFS_VLOW;
  localparam logic [7:0] a_hi  = `TCU_OFS_VHIGH;
  localparam logic [7:0] a_st  = `TCU_OFS_STAT;
  localparam logic [7:0] a_mk  = `TCU_OFS_MASK;
  // Design inputs and bench state
  logic        clk     = 1'b0;
  logic        rst_n   = 1'b0;
  logic [7:0]  awaddr  = 8'h00;
  logic        awvalid = 1'b0;
  logic [31:0] wdata   = 32'h0000_0000;
  logic [3:0]  wstrb   = 4'hF;
  logic        wvalid  = 1'b0;
  logic [7:0]  araddr  = 8'h00;
  logic        arvalid = 1'b0;
  logic [15:0] cnt     = 16'h0000;
  logic        dir     = 1'b1;
  logic        latch   = 1'b0;
  logic        ext     = 1'b0;
  logic        pad;
  logic        awready, wready, arready, bvalid, rvalid, pin_out, oe_n, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [31:0] d;
  logic [15:0] v;
  int          n_fail  = 0;
  int          checks  = 0;
  tcu_row_t    rows [8];

  // Device under test; bready and rready stay high, so every answer is taken at once
  tcu_top DUT (
    .i_clk_sys(clk), .i_rst_n(rst_n),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(1'b1),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(1'b1),
    .i_timebase_one_count(cnt), .i_pin_direction_bit(dir), .i_port_latch(latch),
    .i_capture_pin(pad), .o_capture_pin(pin_out), .o_capture_pin_oe_n(oe_n), .o_irq(irq)
  );

  // Far side of the pin
  tcu_pin_src u_src (
    .i_dut_lvl(pin_out), .i_dut_oe_n(oe_n), .i_ext_lvl(ext), .o_pad(pad)
  );

  // System clock, 100 MHz
  initial begin
    forever #5 clk = ~clk;
  end

  // Compare and report
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Verdict and end of run
  task automatic conclude();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Bus write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] x, input logic [3:0] s = 4'hF,
                    input logic [1:0] er = `TCU_RESP_OKAY);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    awaddr <= a;
    wdata <= {24'h00_0000, x};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (aw && awready === 1'b1) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready === 1'b1) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end while (bvalid !== 1'b1);
    check("bresp", 32'(bresp), 32'(er));
  endtask

  // Bus read: data taken at the edge that sees rvalid
  task automatic rd(input logic [7:0] a, output logic [31:0] q,
                    input logic [1:0] er = `TCU_RESP_OKAY);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    q = rdata;
    check("rresp", 32'(rresp), 32'(er));
  endtask

  // External pulses, each with its own timer count so the captured one is known
  task automatic pulses(input logic [7:0] tg, input int n);
    for (int i = 0; i < n; i++) begin
      // count moves on the system clock only
      cnt <= {tg, 8'(i)};
      @(posedge clk);
      ext <= 1'b1;
      repeat (4) @(posedge clk);
      ext <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask

  // unit off first, then the new mode
  task automatic setm(input logic [3:0] m);
    wr(a_ctl, 8'h00);
    wr(a_ctl, {4'h0, m});
    // drop any flag left by the mode change
    rd(a_st, d);
  endtask

  // Capture value pair as one count
  task automatic getv(output logic [15:0] q);
    rd(a_lo, d);
    q[7:0] = d[7:0];
    rd(a_hi, d);
    q[15:8] = d[7:0];
  endtask

  // Watchdog, far beyond the roughly 800 cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    conclude();
  end

  // Main sequence
  initial begin
    rows = '{'{4'h5, 5'h03, 16'h0002, 1'b1},   // last of three overwrites
             '{4'h4, 5'h03, 16'h0102, 1'b1},
             '{4'h6, 5'h03, 16'h0102, 1'b0},   // count cleared by off
             '{4'h6, 5'h05, 16'h0303, 1'b1},
             '{4'h7, 5'h11, 16'h040F, 1'b1},
             '{4'h1, 5'h02, 16'h040F, 1'b0},
             '{4'h3, 5'h02, 16'h040F, 1'b0},
             '{4'h0, 5'h02, 16'h040F, 1'b0}};
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // Reset values, unmapped place, empty strobe
    for (int k = 0; k < 5; k++) begin
      rd(8'(4 * k), d);
      check("reset", d, 32'h0000_0000);
    end
    rd(8'h14, d, `TCU_RESP_SLVERR);
    check("unmapped", d, 32'h0000_0000);
    wr(8'h14, 8'h01, 4'hF, `TCU_RESP_SLVERR);
    wr(a_mk, 8'h01, 4'h0);
    rd(a_mk, d);
    check("strobe", d, 32'h0000_0000);
    wr(a_mk, 8'h01);
    // Table of capture modes
    for (int r = 0; r < 8; r++) begin
      setm(rows[r].mode);
      pulses(8'(r), int'(rows[r].n));
      repeat (4) @(posedge clk);
      check("irq", 32'(irq), 32'(rows[r].flag));
      rd(a_st, d);
      check("flag", d, 32'(rows[r].flag));
      rd(a_st, d);
      check("cleared", d, 32'h0000_0000);
      getv(v);
      check("value", 32'(v), 32'(rows[r].val));
    end
    // direct prescale switch keeps the count
    setm(`TCU_MODE_RISE4);
    pulses(8'hB0, 2);
    wr(a_ctl, {4'h0, `TCU_MODE_RISE16});
    pulses(8'hC0, 14);
    repeat (4) @(posedge clk);
    getv(v);
    check("early", 32'(v), 32'h0000_C00D);
    // port latch change on a driven pin is an event, seen masked
    wr(a_mk, 8'h00);
    dir <= 1'b0;
    setm(`TCU_MODE_RISE);
    cnt <= 16'h5A5A;
    @(posedge clk);
    latch <= 1'b1;
    repeat (6) @(posedge clk);
    check("oe_n", 32'(oe_n), 32'h0000_0000);
    check("masked", 32'(irq), 32'h0000_0000);
    getv(v);
    check("port", 32'(v), 32'h0000_5A5A);
    wr(a_mk, 8'h01);
    check("unmask", 32'(irq), 32'h0000_0001);
    wr(a_st, 8'h01);
    check("wclear", 32'(irq), 32'h0000_0000);
    // compare match toggles the pin and flags
    latch <= 1'b0;
    cnt <= 16'h0000;
    wr(a_lo, 8'h23);
    wr(a_hi, 8'h01);
    setm(`TCU_MODE_CMPT);
    cnt <= 16'h0123;
    repeat (3) @(posedge clk);
    check("toggle", 32'(pin_out), 32'h0000_0001);
    check("cmp_irq", 32'(irq), 32'h0000_0001);
    dir <= 1'b1;
    setm(`TCU_MODE_OFF);
    check("release", 32'(oe_n), 32'h0000_0001);
    // reset in mid-count clears the prescaler and registers
    setm(`TCU_MODE_RISE4);
    pulses(8'hD0, 2);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(a_ctl, d);
    check("ctl_rst", d, 32'h0000_0000);
    wr(a_ctl, {4'h0, `TCU_MODE_RISE4});
    pulses(8'hE0, 2);
    repeat (4) @(posedge clk);
    getv(v);
    check("ps_rst", 32'(v), 32'h0000_0000);
    conclude();
  end
endmodule // tb_timer_capture_unit
`default_nettype wire
